// >>> dv/analog_front_model.sv
`timescale 1ns/10ps
`default_nettype none

module analog_front_model #(
   parameter bit Slow = 1'b1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Converter side
   input wire logic powerOn,
   input wire logic sampleHold,
   input wire logic [7:0] inputSwitch,
   input wire logic [9:0] tapCode,
   output logic comparatorIn,
   // Pin levels as ideal codes, eight fields of ten bits
   input wire logic [79:0] levels
);
   logic [9:0] held_q;
   logic late_q;
   logic idle_q;
   logic [9:0] picked;
   logic closed;
   logic decision;

   always_comb begin
      picked = 10'h000;
      closed = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (inputSwitch[i]) begin
            picked = levels[i*10 +: 10];
            closed = 1'b1;
         end
      end
   end

   assign decision = (held_q >= tapCode);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         held_q <= 10'h000;
         late_q <= 1'b0;
         idle_q <= 1'b0;
      end else begin
         if (sampleHold && closed) begin
            held_q <= picked;
         end
         late_q <= decision;
         idle_q <= ~idle_q;
      end
   end

   // An unpowered comparator gives no stable answer, so it toggles.
   assign comparatorIn = powerOn ? (Slow ? late_q : decision) : idle_q;

endmodule : analog_front_model

`default_nettype wire

// >>> dv/sar_adc_channel_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_consts.svh"

`define CHECK(got, exp, msg) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected at %0t: %s", $time, msg); \
   end \
end

module sar_adc_channel_control_bench;
   import sar_adc_pkg::*;

   localparam int Limit = 20000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] busAddr = 16'h0000;
   logic [7:0] busWrData = 8'h00;
   logic busWrite = 1'b0;
   logic busRead = 1'b0;
   logic [7:0] busRdData;
   logic busWait;
   logic comparatorIn;
   logic comparatorPowerOn;
   logic sampleHold;
   logic [7:0] inputSwitch;
   logic [9:0] tapCode;
   logic [7:0] pinOutEnable_n;
   logic [7:0] digitalInEnable;
   logic conversionEndIrq;
   logic [79:0] levels = {10'h300, 10'h001, 10'h2AA, 10'h155, 10'h1FF, 10'h200, 10'h3FF, 10'h000};
   logic watch = 1'b0;
   logic [2:0] expCh = 3'h0;
   logic [3:0] waits;
   logic [15:0] span;
   logic [7:0] dmask;
   logic [15:0] expSpan;
   int divNow = 0;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   sar_adc_channel_control u_sar_adc_channel_control (.clk(clk), .rst_n(rst_n),
      .busAddr(busAddr), .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead),
      .busRdData(busRdData), .busWait(busWait), .comparatorIn(comparatorIn),
      .comparatorPowerOn(comparatorPowerOn), .sampleHold(sampleHold),
      .inputSwitch(inputSwitch), .tapCode(tapCode), .pinOutEnable_n(pinOutEnable_n),
      .digitalInEnable(digitalInEnable), .conversionEndIrq(conversionEndIrq));

   analog_front_model u_analog_front_model (.clk(clk), .rst_n(rst_n),
      .powerOn(comparatorPowerOn), .sampleHold(sampleHold), .inputSwitch(inputSwitch),
      .tapCode(tapCode), .comparatorIn(comparatorIn), .levels(levels));

   // -------------------------------------------------------------------------
   // Bus tasks: each starts at any time and ends at a falling edge
   // -------------------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      busAddr <= a;
      busWrData <= d;
      busWrite <= 1'b1;
      waits = 4'h0;
      @(negedge clk);
      while (busWait === 1'b1 && waits < 4'hF) begin
         waits++;
         @(negedge clk);
      end
      @(posedge clk);
      busWrite <= 1'b0;
      @(negedge clk);
   endtask : wr

   task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge clk);
      busRead <= 1'b0;
      @(negedge clk);
      `CHECK(busRdData, exp, "read data")
   endtask : rdChk

   task automatic checkResult(input logic [9:0] v);
      rdChk(`ADC_ADDR_RES16_HI, v[9:2]);
      rdChk(`ADC_ADDR_RES16_LO, {v[1:0], 6'h00});
      rdChk(`ADC_ADDR_RES8, v[9:2]);
   endtask : checkResult

   // Counts falling edges until the end request; the span excludes two edges.
   task automatic waitIrq(output logic [15:0] n);
      n = 16'h0000;
      watch = 1'b1;
      @(negedge clk);
      while (conversionEndIrq !== 1'b1 && n < 16'h0BB8) begin
         n++;
         @(negedge clk);
      end
      watch = 1'b0;
      `CHECK(conversionEndIrq, 1'b1, "no end request")
      @(negedge clk);
      `CHECK(conversionEndIrq, 1'b0, "end request too long")
   endtask : waitIrq

   task automatic quiet(input int cnt);
      repeat (cnt) begin
         @(negedge clk);
         `CHECK(conversionEndIrq, 1'b0, "end request while stopped")
      end
   endtask : quiet

   task end_of_test;
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // -------------------------------------------------------------------------
   // Monitors
   // -------------------------------------------------------------------------
   always @(negedge clk) begin
      if (watch && sampleHold === 1'b1) begin
         `CHECK(inputSwitch, 8'h01 << expCh, "switch")
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == Limit) begin
         fails++;
         end_of_test();
      end
   end

   // -------------------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      rdChk(`ADC_ADDR_DIRECTION, 8'hFF);
      rdChk(`ADC_ADDR_CHANNEL, 8'h00);
      rdChk(`ADC_ADDR_PINCFG, 8'h00);
      rdChk(16'hFF30, 8'h00);
      checkResult(10'h000);
      `CHECK(pinOutEnable_n, 8'hFF, "pins after reset")
      for (int n = 0; n <= 8; n++) begin
         wr(`ADC_ADDR_PINCFG, 8'(n));
         `CHECK(waits, 4'h1, "split wait")
         wr(`ADC_ADDR_DIRECTION, 8'h5A ^ 8'(n));
         `CHECK(waits, 4'h0, "direction wait")
         dmask = 8'((9'h001 << n) - 9'h001);
         `CHECK(digitalInEnable, dmask, "split")
         `CHECK(pinOutEnable_n, (8'h5A ^ 8'(n)) | ~dmask, "direction")
         rdChk(`ADC_ADDR_PINCFG, 8'(n));
      end
      wr(`ADC_ADDR_PINCFG, 8'h00);
      wr(`ADC_ADDR_DIRECTION, 8'hFF);
      wr(`ADC_ADDR_MODE, 8'h01);
      `CHECK(comparatorPowerOn, 1'b1, "power on")
      rdChk(`ADC_ADDR_MODE, 8'h01);
      repeat (125) @(negedge clk);
      for (int c = 0; c < 8; c++) begin
         expCh = 3'(c);
         wr(`ADC_ADDR_CHANNEL, {5'h00, expCh});
         `CHECK(waits, 4'h1, "channel wait")
         wr(`ADC_ADDR_MODE, 8'h81);
         waitIrq(span);
         checkResult(levels[c*10 +: 10]);
         wr(`ADC_ADDR_MODE, 8'h01);
      end
      // Back to back conversions give the period set by the clock field, mode bits 5..3.
      for (int f = 0; f < 6; f++) begin
         case (f)
            0: divNow = `ADC_DIV_FR0;
            1: divNow = `ADC_DIV_FR1;
            2: divNow = `ADC_DIV_FR2;
            3: divNow = `ADC_DIV_FR3;
            4: divNow = `ADC_DIV_FR4;
            default: divNow = `ADC_DIV_FR5;
         endcase
         expSpan = 16'((`ADC_CLEAR_TICKS + `ADC_SAMPLE_TICKS + 10) * divNow - 2);
         wr(`ADC_ADDR_MODE, 8'h81 | 8'(f << 3));
         waitIrq(span);
         waitIrq(span);
         `CHECK(span, expSpan, "period")
         wr(`ADC_ADDR_MODE, 8'h01);
      end
      expCh = 3'h1;
      wr(`ADC_ADDR_CHANNEL, 8'h01);
      wr(`ADC_ADDR_MODE, 8'h81);
      waitIrq(span);
      checkResult(levels[19:10]);
      quiet(100);
      expCh = 3'h6;
      wr(`ADC_ADDR_CHANNEL, 8'h06);
      waitIrq(span);
      `CHECK(span > 16'h00F0, 1'b1, "no restart")
      checkResult(10'h001);
      wr(`ADC_ADDR_CHANNEL, 8'h01);
      quiet(150);
      wr(`ADC_ADDR_MODE, 8'h01);
      quiet(400);
      checkResult(10'h001);
      wr(`ADC_ADDR_MODE, 8'h80);
      `CHECK(comparatorPowerOn, 1'b0, "power off")
      quiet(400);
      end_of_test();
   end

endmodule : sar_adc_channel_control_bench

`default_nettype wire

// >>> src/sar_adc_channel_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_consts.svh"

// Summary of operation
// [RQ1] Channel select bits 2..0 route analog input 0..7 to sample/hold.
// [RQ2] Software writes zeros to channel select bits 7..3.
// [RQ3] Pin split n makes the n lowest pins digital, rest analog.
// [RQ4] Direction bit 0 enables the output buffer, 1 disables it.
// [RQ5] Direction register resets to all ones, all pins input.
// [RQ6] Software sets direction 1 on every analog input pin.
// [RQ7] Pin function follows split, direction and channel select together.
// [RQ8] Writes to channel select or pin split insert one bus wait cycle.
// [RQ9] Enable bit powers the comparator; conversion needs it set.
// [RQ10] Mode bits 5..1 set the conversion clock and step durations; here only bits 5..3 pick the divisor, step tick counts are fixed.
// [RQ11] Start bit begins conversion; later steps run in hardware.
// [RQ12] Sample for the set time, then hold until conversion ends.
// [RQ13] First trial sets bit 9 with tap at half reference.
// [RQ14] Bit 8 trial uses tap three or one quarter; keep on compare.
// [RQ15] After ten trials copy result to both registers and pulse request.
// [RQ16] Conversions repeat while start stays set; clearing start stops.
// [RQ17] Software waits one microsecond after enable before starting.
// [RQ18] Software writes a new channel then runs the start sequence.
// [RQ19] Channel write during conversion aborts it and restarts if started.
// [RQ20] Clearing start halts at once; results keep the last value.
// [RQ21] 16-bit result left-justified, low six zero; 8-bit holds top eight.
// [RQ22] Tap code equals trial value; comparator sampled once per trial.
// [RQ23] Results reset to zero; end request is a one-cycle pulse.
module sar_adc_channel_control
   import sar_adc_pkg::*;
#(
   parameter logic [4:0] ClearTicks = `ADC_CLEAR_TICKS,
   parameter logic [4:0] SampleTicks = `ADC_SAMPLE_TICKS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Peripheral register bus
   input wire logic [15:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWrite,
   input wire logic busRead,
   output logic [7:0] busRdData,
   output logic busWait,
   // Analog front end
   input wire logic comparatorIn,
   output logic comparatorPowerOn,
   output logic sampleHold,
   output logic [7:0] inputSwitch,
   output logic [9:0] tapCode,
   // Shared pins
   output logic [7:0] pinOutEnable_n,
   output logic [7:0] digitalInEnable,
   // Events
   output logic conversionEndIrq
);

   // -------------------------------------------------------------------------
   // State and decode
   // -------------------------------------------------------------------------
   adc_state_type s_q;
   adc_state_type s_d;
   logic tick;
   logic [3:0] divisor;
   logic divClear;
   logic waitAddr;
   logic wrCommit;
   logic chanCommit;
   logic modeCommit;
   logic running;
   logic restart;
   logic [7:0] analogMask;
   logic [2:0] frSel;

   assign waitAddr = (busAddr == `ADC_ADDR_CHANNEL) || (busAddr == `ADC_ADDR_PINCFG);
   // The access that needs a wait is held off for one cycle before it lands.
   assign busWait = busWrite && waitAddr && !s_q.waitDone; // see [RQ8]
   assign wrCommit = busWrite && !busWait;
   assign chanCommit = wrCommit && (busAddr == `ADC_ADDR_CHANNEL);
   assign modeCommit = wrCommit && (busAddr == `ADC_ADDR_MODE);
   assign running = s_q.state != ST_IDLE;
   assign restart = chanCommit && running; // see [RQ19]
   assign frSel = s_q.mode[`ADC_MODE_FR_LSB +: 3];

   // -------------------------------------------------------------------------
   // Conversion clock
   // -------------------------------------------------------------------------
   always_comb begin
      case (frSel) // see [RQ10]
         3'd0: divisor = `ADC_DIV_FR0;
         3'd1: divisor = `ADC_DIV_FR1;
         3'd2: divisor = `ADC_DIV_FR2;
         3'd3: divisor = `ADC_DIV_FR3;
         3'd4: divisor = `ADC_DIV_FR4;
         default: divisor = `ADC_DIV_FR5;
      endcase
   end

   // A restart also realigns the divider so every step gets full ticks.
   assign divClear = !running || restart;

   sar_clock_divider u_div (
      .clk(clk),
      .rst_n(rst_n),
      .clear(divClear),
      .divisor(divisor),
      .tick(tick)
   );

   // -------------------------------------------------------------------------
   // Pin function
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pin
         // Out-of-range split codes fall to all-digital, the safe side.
         assign analogMask[gi] = (4'(gi) >= s_q.pinSplit); // see [RQ3]
         // An analog pin never drives, whatever its direction bit holds.
         assign pinOutEnable_n[gi] = s_q.direction[gi] || analogMask[gi]; // see [RQ4]
         assign digitalInEnable[gi] = !analogMask[gi];
         assign inputSwitch[gi] = sampleHold && analogMask[gi] && s_q.direction[gi]
            && (s_q.channel == 3'(gi)); // see [RQ1] see [RQ7]
      end
   endgenerate

   assign comparatorPowerOn = s_q.mode[`ADC_MODE_ENABLE_BIT]; // see [RQ9]
   assign sampleHold = (s_q.state == ST_SAMPLE); // see [RQ12]
   assign tapCode = s_q.sar; // see [RQ22]
   assign conversionEndIrq = s_q.irq;
   assign busRdData = s_q.rdData;

   // -------------------------------------------------------------------------
   // Registers and sequencer
   // -------------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.irq = 1'b0; // see [RQ23]
      s_d.compMeta = comparatorIn;
      s_d.compSync = s_q.compMeta;
      s_d.waitDone = busWait;

      if (busRead) begin
         case (busAddr)
            `ADC_ADDR_DIRECTION: s_d.rdData = s_q.direction;
            `ADC_ADDR_CHANNEL: s_d.rdData = {5'h00, s_q.channel};
            `ADC_ADDR_PINCFG: s_d.rdData = {4'h0, s_q.pinSplit};
            `ADC_ADDR_MODE: s_d.rdData = s_q.mode;
            `ADC_ADDR_RES16_LO: s_d.rdData = {s_q.result[1:0], 6'h00}; // see [RQ21]
            `ADC_ADDR_RES16_HI: s_d.rdData = s_q.result[9:2];
            `ADC_ADDR_RES8: s_d.rdData = s_q.result[9:2]; // see [RQ21]
            default: s_d.rdData = 8'h00;
         endcase
      end

      if (wrCommit) begin
         case (busAddr)
            `ADC_ADDR_DIRECTION: s_d.direction = busWrData;
            `ADC_ADDR_CHANNEL: s_d.channel = busWrData[2:0]; // see [RQ1]
            `ADC_ADDR_PINCFG: s_d.pinSplit = busWrData[3:0];
            `ADC_ADDR_MODE: s_d.mode = busWrData & `ADC_MODE_RES_MASK;
            default: s_d.mode = s_q.mode;
         endcase
      end

      case (s_q.state)
         ST_IDLE: begin
            s_d.tickCnt = 5'd0;
            if (s_q.mode[`ADC_MODE_START_BIT] && s_q.mode[`ADC_MODE_ENABLE_BIT]) begin
               s_d.state = ST_CLEAR; // see [RQ11]
            end
         end
         ST_CLEAR: begin
            s_d.sar = 10'h000;
            if (tick) begin
               s_d.tickCnt = s_q.tickCnt + 5'd1;
               if (s_q.tickCnt == ClearTicks - 5'd1) begin
                  s_d.tickCnt = 5'd0;
                  s_d.state = ST_SAMPLE;
               end
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               s_d.tickCnt = s_q.tickCnt + 5'd1;
               if (s_q.tickCnt == SampleTicks - 5'd1) begin
                  s_d.tickCnt = 5'd0;
                  s_d.state = ST_TRIAL;
                  s_d.sar = `ADC_SAR_MSB_VALUE; // see [RQ13]
                  s_d.bitIdx = 4'd9;
               end
            end
         end
         ST_TRIAL: begin
            if (tick) begin
               // The comparator reads high when the held input reaches the tap.
               s_d.sar[s_q.bitIdx] = s_q.compSync; // see [RQ13] see [RQ14] see [RQ22]
               if (s_q.bitIdx == 4'd0) begin
                  s_d.result = {s_q.sar[9:1], s_q.compSync}; // see [RQ15]
                  s_d.irq = 1'b1; // see [RQ15]
                  s_d.state = ST_CLEAR; // see [RQ16]
               end else begin
                  s_d.bitIdx = s_q.bitIdx - 4'd1;
                  s_d.sar[s_q.bitIdx - 4'd1] = 1'b1; // see [RQ14]
               end
            end
         end
         default: s_d.state = ST_IDLE;
      endcase

      // A channel write while running throws away the trial and starts again from the clear step.
      if (restart) begin
         s_d.state = ST_CLEAR; // see [RQ19]
         s_d.tickCnt = 5'd0;
         s_d.result = s_q.result;
         s_d.irq = 1'b0;
      end
      // Clearing start or enable stops at once; the last result stays put.
      if (modeCommit && !(busWrData[`ADC_MODE_START_BIT] && busWrData[`ADC_MODE_ENABLE_BIT])) begin
         s_d.state = ST_IDLE; // see [RQ16] see [RQ20]
         s_d.result = s_q.result;
         s_d.irq = 1'b0;
         s_d.sar = 10'h000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.direction <= `ADC_DIRECTION_RESET; // see [RQ5]
         s_q.channel <= `ADC_CHANNEL_RESET;
         s_q.pinSplit <= `ADC_PINCFG_RESET;
         s_q.mode <= `ADC_MODE_RESET;
         s_q.result <= `ADC_RESULT_RESET; // see [RQ23]
         s_q.state <= ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_irq_single: assert property (conversionEndIrq |=> !conversionEndIrq) // see [RQ23]
      else $error("End request longer than one cycle.");
   chk_result_update: assert property ($changed(s_q.result) |-> conversionEndIrq) // see [RQ15]
      else $error("Result changed without end request.");
   chk_stop_halts: assert property ( // see [RQ20]
      (running && modeCommit && !busWrData[`ADC_MODE_START_BIT])
      |=> (s_q.state == ST_IDLE) && $stable(s_q.result) [*2])
      else $error("Conversion not halted by start clear.");
   chk_hold_trial: assert property ((s_q.state == ST_TRIAL) |-> !sampleHold && inputSwitch == 8'h00) // see [RQ12]
      else $error("Sample switch closed during trial.");
   chk_msb_first: assert property ($rose(s_q.state == ST_TRIAL) |-> tapCode == 10'h200) // see [RQ13]
      else $error("First trial tap not at half reference.");
   chk_needs_enable: assert property ( // see [RQ9]
      $rose(running) |-> $past(comparatorPowerOn) && comparatorPowerOn)
      else $error("Conversion started with comparator off.");
   chk_dir_reset: assert property ($past(!rst_n) |-> s_q.direction == 8'hFF) // see [RQ5]
      else $error("Direction register not all ones after reset.");
   chk_write_wait: assert property ( // see [RQ8]
      (busWrite && waitAddr && !$past(busWait)) |-> busWait ##1 !busWait)
      else $error("Wait cycle missing on channel or split write.");
   chk_abort_restart: assert property ( // see [RQ19]
      (restart && !modeCommit) |=> s_q.state == ST_CLEAR && !conversionEndIrq)
      else $error("Channel write did not restart conversion.");
   chk_analog_noout: assert property ((pinOutEnable_n & analogMask) == analogMask) // see [RQ3]
      else $error("Analog pin output buffer enabled.");
   chk_sample_len: assert property ( // see [RQ12]
      $rose(sampleHold) |-> sampleHold [*8])
      else $error("Sample phase shorter than minimum.");

   // The switch and read paths are watched every cycle: a wrong switch would
   // otherwise show only as a bad level, long after the cycle that caused it.
   chk_switch_onehot: assert property ($onehot0(inputSwitch)) // see [RQ1]
      else $error("More than one input switch closed.");
   chk_switch_analog: assert property ( // see [RQ7]
      (inputSwitch & ~(analogMask & s_q.direction)) == 8'h00)
      else $error("Input switch closed on a digital or output pin.");
   chk_wait_plain: assert property ((busWrite && !waitAddr) |-> !busWait) // see [RQ8]
      else $error("Wait cycle on a register that takes none.");
   chk_low_zero: assert property ( // see [RQ21]
      $past(busRead) && ($past(busAddr) == `ADC_ADDR_RES16_LO) |-> busRdData[5:0] == 6'h00)
      else $error("Low result byte shows bits below the result.");
   chk_irq_trial: assert property ( // see [RQ15]
      conversionEndIrq |-> $past(s_q.state) == ST_TRIAL)
      else $error("End request without a finished trial.");
   chk_irq_running: assert property (conversionEndIrq |-> running) // see [RQ16]
      else $error("End request after conversion stopped.");

   // Cover points mark the scenarios that the bench is meant to reach.
   cov_end: cover property (conversionEndIrq);
   cov_all_digital: cover property (s_q.pinSplit == 4'd8);
   cov_back_to_back: cover property (conversionEndIrq ##[1:1000] conversionEndIrq);
   cov_abort: cover property (restart);
   cov_stop: cover property (running && modeCommit && !busWrData[`ADC_MODE_START_BIT]);

endmodule : sar_adc_channel_control

`default_nettype wire

// >>> src/sar_adc_consts.svh
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define ADC_ADDR_DIRECTION 16'hFF22
`define ADC_ADDR_CHANNEL 16'hFF29
`define ADC_ADDR_PINCFG 16'hFF2F
`define ADC_ADDR_MODE 16'hFF28
`define ADC_ADDR_RES16_LO 16'hFF08
`define ADC_ADDR_RES16_HI 16'hFF09
`define ADC_ADDR_RES8 16'hFF0A

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define ADC_MODE_ENABLE_BIT 0
`define ADC_MODE_START_BIT 7
`define ADC_MODE_TIME_LSB 1
`define ADC_MODE_FR_LSB 3
`define ADC_MODE_RES_MASK 8'hBF
`define ADC_DIRECTION_RESET 8'hFF
`define ADC_CHANNEL_RESET 3'h0
`define ADC_PINCFG_RESET 4'h0
`define ADC_MODE_RESET 8'h00
`define ADC_RESULT_RESET 10'h000
`define ADC_SAR_MSB_VALUE 10'h200

// ----------------------------------------------------------------------------
// Timing counts, in converter clock ticks or clk cycles per tick
// ----------------------------------------------------------------------------
`define ADC_CLEAR_TICKS 5'd2
`define ADC_SAMPLE_TICKS 5'd12
`define ADC_DIV_FR0 4'd12
`define ADC_DIV_FR1 4'd8
`define ADC_DIV_FR2 4'd6
`define ADC_DIV_FR3 4'd4
`define ADC_DIV_FR4 4'd3
`define ADC_DIV_FR5 4'd2

`endif

// >>> src/sar_adc_pkg.sv
package sar_adc_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CLEAR,
      ST_SAMPLE,
      ST_TRIAL
   } seq_state_type;

   typedef struct packed {
      logic [7:0] direction;
      logic [2:0] channel;
      logic [3:0] pinSplit;
      logic [7:0] mode;
      seq_state_type state;
      logic [9:0] sar;
      logic [3:0] bitIdx;
      logic [4:0] tickCnt;
      logic [9:0] result;
      logic irq;
      logic waitDone;
      logic compMeta;
      logic compSync;
      logic [7:0] rdData;
   } adc_state_type;

   typedef struct packed {
      logic [3:0] cnt;
   } div_state_type;

endpackage : sar_adc_pkg

// >>> src/sar_clock_divider.sv
`timescale 1ns/10ps
`default_nettype none

module sar_clock_divider
   import sar_adc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic clear,
   input wire logic [3:0] divisor,
   // Tick
   output logic tick
);

   div_state_type s_q;
   div_state_type s_d;

   assign tick = !clear && (s_q.cnt == divisor - 4'd1);

   always_comb begin
      s_d = s_q;
      if (clear || tick) begin
         s_d.cnt = 4'd0;
      end else begin
         s_d.cnt = s_q.cnt + 4'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : sar_clock_divider

`default_nettype wire
